//--- tb/dcs_drum_model.sv
// dcs_drum_model: drum clock track, origin mark and analog converter
// assumes in_conv is the input conversion word level
`timescale 1ns/1ns
`default_nettype none
module dcs_drum_model
    import dcs_pkg::*;
#(
    parameter int HALF = 8,
    parameter int LAT  = 3
) (
    input  wire logic              ref_clk,
    input  wire logic              slow,
    input  wire logic              in_conv,
    output var  logic              track,
    output var  logic              origin,
    output var  logic              res_valid,
    input  wire logic              res_ready,
    output var  logic [WORD_W-1:0] res_data
);
    localparam int REV_BITS = SECTORS * DIGITS_PER_WORD;
    int                ph     = 0;
    int                bit_n  = 0;
    int                wait_n = -1;
    logic              last_in = 1'b0;
    logic [WORD_W-1:0] seq     = 20'h00001;
    initial begin
        track = 1'b0;
        origin = 1'b0;
        res_valid = 1'b0;
        res_data = 20'hFFFFF;
    end
    // track runs free, one origin mark per revolution
    always @(posedge ref_clk) begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1) begin
            track <= !track;
            if (!track) begin
                bit_n <= (bit_n == REV_BITS - 1) ? 0 : bit_n + 1;
                origin <= (bit_n == REV_BITS - 1);
            end
        end
    end
    // result held until taken
    always @(posedge ref_clk) begin
        last_in <= in_conv;
        if (in_conv && !last_in) begin
            wait_n <= slow ? LAT * 40 : LAT;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end else if (wait_n == 0 && !(res_valid && res_ready)) begin
            res_valid <= 1'b1;
            res_data <= seq;
            wait_n <= -1;
        end
        if (res_valid && res_ready) begin
            res_valid <= 1'b0;
            res_data <= ~seq;
            seq <= seq + 20'h00001;
        end
    end
endmodule // dcs_drum_model
`default_nettype wire

//--- tb/dcs_scheduler_asserts.sv
// dcs_scheduler_asserts: port checks of the converter scheduler
// assumes a drum track half period of 8 clocks
`timescale 1ns/1ns
`default_nettype none
module dcs_scheduler_asserts
    import dcs_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        wr_valid,
    input wire logic        wr_ready,
    input wire dcs_wr_t     wr_word,
    input wire dcs_cv_ctl_t cv_ctl,
    input wire logic        clk_phase_a,
    input wire logic        clk_phase_b,
    input wire logic        sector_parity_bit
);
    localparam int TRK_HALF = 8;
    logic [7:0] conv_n;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // starts since the last pass of sector 0
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            conv_n <= 8'h00;
        end else if ($changed(cv_ctl.sector) && cv_ctl.sector == 7'h00) begin
            conv_n <= 8'h00;
        end else if ($rose(cv_ctl.in_conv) || $rose(cv_ctl.out_conv)) begin
            conv_n <= conv_n + 8'h01;
        end
    end
    sequence s_in_end;
        $fell(cv_ctl.in_conv);
    endsequence
    in_then_write_a: assert property (s_in_end |-> cv_ctl.in_write)
        else $error("input without write");
    out_after_fetch_a: assert property ($rose(cv_ctl.out_conv) |-> $past(cv_ctl.out_fetch))
        else $error("output conversion without fetch");
    conv_limit_a: assert property (conv_n <= 8'h40)
        else $error("too many conversions in one revolution");
    out_blocked_a: assert property (cv_ctl.out_conv |-> !(cv_ctl.in_conv || cv_ctl.in_write))
        else $error("output conversion during input");
    fetch_allowed_a: assert property (cv_ctl.out_fetch |-> !cv_ctl.in_conv)
        else $error("fetch during input conversion");
    fetch_even_a: assert property (cv_ctl.out_fetch |-> !cv_ctl.sector[0])
        else $error("fetch in odd sector");
    conv_odd_a: assert property (cv_ctl.out_conv |-> cv_ctl.sector[0])
        else $error("output conversion in even sector");
    clear_before_in_a: assert property (cv_ctl.reg_clear |-> ##[0:20] cv_ctl.in_conv)
        else $error("clear without input");
    parity_even_a: assert property ($rose(cv_ctl.out_fetch) |-> ##1 (!sector_parity_bit) [*8])
        else $error("parity not even in fetch word");
    phase_half_a: assert property (clk_phase_a |-> ##TRK_HALF clk_phase_b)
        else $error("phase b misplaced");
    apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer late");
    wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
        else $error("write word dropped while stalled");
endmodule // dcs_scheduler_asserts
bind dcs_scheduler dcs_scheduler_asserts u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .cv_ctl(cv_ctl),
    .clk_phase_a(clk_phase_a), .clk_phase_b(clk_phase_b),
    .sector_parity_bit(sector_parity_bit)
);
`default_nettype wire

//--- tb/drum_converter_scheduler_bench.sv
// drum_converter_scheduler_bench: self-checking bench of dcs_scheduler
// assumes dcs_drum_model on the drum side
`timescale 1ns/1ns
`default_nettype none
module drum_converter_scheduler_bench
    import dcs_pkg::*;
;
    typedef struct {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
        logic        er;
    } dcs_row_t;
    localparam int WORD_CYC = 16 * DIGITS_PER_WORD;
    logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, track, origin, res_valid, res_ready, wr_valid, er;
    logic [1:0]  gate_option = 2'b00;
    logic steer_a = 1'b0, steer_b = 1'b0, steer_c = 1'b0, wr_ready = 1'b1, slow = 1'b0;
    logic [WORD_W-1:0] res_data, first_data = 20'h00000;
    dcs_wr_t     wr_word;
    dcs_cv_ctl_t cv_ctl, last_ctl;
    int error_cnt = 0, checked = 0, n_in = 0, n_fetch = 0, n_out = 0, n_wr = 0;
    int b0, b1, b2, n;
    dcs_row_t rows [10];
    always #5 ref_clk = ~ref_clk;
    dcs_scheduler u_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_track_reader(track), .drum_origin(origin),
        .gate_option(gate_option), .steer_a_ext(steer_a), .steer_b_ext(steer_b),
        .steer_c_ext(steer_c), .res_valid(res_valid), .res_ready(res_ready),
        .res_data(res_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
        .cv_ctl(cv_ctl), .clk_phase_a(), .clk_phase_b(), .sector_parity_bit());
    dcs_drum_model u_drum (.ref_clk(ref_clk), .slow(slow), .in_conv(cv_ctl.in_conv),
        .track(track), .origin(origin), .res_valid(res_valid), .res_ready(res_ready),
        .res_data(res_data));
    // event counts sampled mid-cycle
    always @(negedge ref_clk) begin
        last_ctl <= cv_ctl;
        n_in <= n_in + int'(cv_ctl.in_conv && !last_ctl.in_conv);
        n_fetch <= n_fetch + int'(cv_ctl.out_fetch && !last_ctl.out_fetch);
        n_out <= n_out + int'(cv_ctl.out_conv && !last_ctl.out_conv);
        if (wr_valid && wr_ready) begin
            n_wr <= n_wr + 1;
            if (n_wr == 0) first_data <= wr_word.data;
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        error_cnt++;
        $display("Error at %0t: %s", $time, msg);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
    endtask
    task automatic chk_b(input logic got, input logic exp);
        checked++;
        if (got !== exp) fail("flag mismatch");
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) fail("bus timeout");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic [1:0] opt);
        rstn <= 1'b0;
        gate_option <= opt;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic mark();
        repeat (2 * WORD_CYC) @(posedge ref_clk);
        b0 = n_fetch;
        b1 = n_out;
        b2 = n_in;
    endtask
    initial begin
        rows = '{'{0, REG_CTRL, 0, 32'h7F, 32'h03, 0}, '{0, REG_REVLEN, 0, 32'hF, 32'hF, 0},
            '{0, REG_EVMASK, 0, '1, 0, 0}, '{0, 8'h18, 0, '1, 0, 1},
            '{1, REG_EVMASK, 32'hA5A55A5A, '1, 0, 0}, '{0, REG_EVMASK, 0, '1, 32'hA5A55A5A, 0},
            '{1, 8'h1C, '1, '1, 0, 1}, '{1, REG_REVLEN, 32'h7, '1, 0, 0},
            '{0, REG_REVLEN, 0, 32'hF, 32'h7, 0}, '{0, REG_STATUS, 0, 32'h30000, 32'h30000, 0}};
        for (int o = 0; o < 4; o++) begin
            do_reset(2'(o));
            apb(1'b0, REG_STATUS, 32'h0);
            chk(rd & 32'h30000, 32'(o) << 16);
        end
        gate_option <= 2'b00;
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd & 32'h30000, 32'h30000);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(rd & rows[i].m, rows[i].e);
            chk_b(er, rows[i].er);
        end
        mark();
        repeat (8 * WORD_CYC) @(posedge ref_clk);
        chk_b(n_fetch - b0 >= 3, 1'b1);
        chk_b(n_out - b1 >= 3, 1'b1);
        chk_b(n_in == b2, 1'b1);
        steer_b <= 1'b1;
        mark();
        repeat (8 * WORD_CYC) @(posedge ref_clk);
        chk_b(n_out == b1, 1'b1);
        steer_b <= 1'b0;
        slow <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h07);
        mark();
        repeat (16 * WORD_CYC) @(posedge ref_clk);
        chk_b(n_in - b2 >= 1, 1'b1);
        apb(1'b1, REG_CTRL, 32'h43);
        mark();
        repeat (16 * WORD_CYC) @(posedge ref_clk);
        chk_b(n_in - b2 >= 3, 1'b1);
        chk({12'h0, first_data}, 32'h1);
        steer_a <= 1'b1;
        mark();
        repeat (8 * WORD_CYC) @(posedge ref_clk);
        chk_b(n_in == b2, 1'b1);
        steer_a <= 1'b0;
        slow <= 1'b0;
        wr_ready <= 1'b0;
        n = 0;
        while ((res_ready !== 1'b0 || res_valid !== 1'b1) && n < 50000) begin
            @(negedge ref_clk);
            n++;
        end
        chk_b(res_ready, 1'b0);
        apb(1'b0, REG_REFUSE, 32'h0);
        chk_b(rd != 32'h0, 1'b1);
        b0 = n_wr;
        steer_a <= 1'b1;
        wr_ready <= 1'b1;
        n = 0;
        while (n_wr - b0 < FIFO_DEPTH + 1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        chk_b(n_wr - b0 >= FIFO_DEPTH + 1, 1'b1);
        chk_b(res_ready, 1'b1);
        print_verdict();
    end
endmodule // drum_converter_scheduler_bench
`default_nettype wire

//--- verilog/dcs_fifo.sv
// dcs_fifo: result buffer with registered output stage
// assumes one clock; in_ready is registered, out_ready is used unregistered
`timescale 1ns/1ns
`default_nettype none
module dcs_fifo #(
    parameter int W     = 30,
    parameter int DEPTH = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   cnt;

    wire         push     = in_valid & in_ready;
    wire         load     = ~out_valid | out_ready;
    wire         pop      = load & (cnt != '0);
    wire [AW:0]  next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wptr      <= '0;
            rptr      <= '0;
            cnt       <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            cnt      <= next_cnt;
            in_ready <= next_cnt < (AW+1)'(DEPTH);
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr     <= rptr + 1'b1;
                out_data <= mem[rptr];
            end
            if (load) begin
                out_valid <= pop;
            end
        end
    end
endmodule // dcs_fifo
`default_nettype wire

//--- verilog/dcs_pkg.sv
// dcs_pkg: constants, types and register map of the drum converter scheduler
// assumes a 100 MHz ref_clk and a drum clock track sampled as a pin
package dcs_pkg;
    // timing
    localparam int REF_PERIOD_NS    = 10;
    localparam int CLK_A_PERIOD_NS  = 6500;
    localparam int CLK_A_CYCLES     = CLK_A_PERIOD_NS / REF_PERIOD_NS;
    localparam int CLK_FAULT_CYCLES = 2 * CLK_A_CYCLES;
    localparam int TRACK_FREQ_HZ    = 153600;
    localparam int DRUM_RPM         = 3600;
    localparam int SECTORS          = 128;
    localparam int BITS_PER_REV     = TRACK_FREQ_HZ * 60 / DRUM_RPM;
    localparam int DIGITS_PER_WORD  = BITS_PER_REV / SECTORS;
    localparam logic [4:0] LAST_DIGIT = 5'(DIGITS_PER_WORD - 1);
    localparam logic [6:0] MAX_CONV_PER_REV = 7'h40;
    localparam logic [2:0] OUT_TRACK = 3'h7;
    localparam int WORD_W           = 20;
    localparam int FIFO_DEPTH       = 16;
    // register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_REVLEN = 8'h04;
    localparam logic [7:0] REG_EVMASK = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_COUNT  = 8'h10;
    localparam logic [7:0] REG_REFUSE = 8'h14;
    // control fields
    localparam int CTRL_EN      = 0;
    localparam int CTRL_OUT_EN  = 1;
    localparam int CTRL_EVERY   = 2;
    localparam int CTRL_STEER_A = 4;
    localparam int CTRL_STEER_B = 5;
    localparam int CTRL_STEER_C = 6;
    localparam logic [6:0]  CTRL_RST   = 7'h03;
    localparam logic [3:0]  REVLEN_RST = 4'hF;
    localparam logic [31:0] EVMASK_RST = 32'h0000_0000;
    // status and count fields
    localparam int ST_SECTOR = 0;
    localparam int ST_DIGIT  = 8;
    localparam int ST_OPT    = 16;
    localparam int ST_STATE  = 20;
    localparam int ST_FAULT  = 24;
    localparam int ST_FINAL  = 25;
    localparam int CN_CONV   = 0;
    localparam int CN_REV    = 8;
    localparam int CN_STEP   = 16;

    typedef enum logic [1:0] {
        DCS_OPT_G4  = 2'b00,
        DCS_OPT_G8  = 2'b01,
        DCS_OPT_G16 = 2'b10,
        DCS_OPT_G32 = 2'b11
    } dcs_opt_t;

    typedef enum logic [2:0] {
        CV_IDLE      = 3'b000,
        CV_IN_CONV   = 3'b001,
        CV_IN_WRITE  = 3'b010,
        CV_OUT_FETCH = 3'b011,
        CV_OUT_CONV  = 3'b100
    } dcs_cv_state_t;

    typedef struct packed {
        logic [2:0]        track;
        logic [6:0]        sector;
        logic [WORD_W-1:0] data;
    } dcs_wr_t;

    typedef struct packed {
        logic       in_conv;
        logic       in_write;
        logic       out_fetch;
        logic       out_conv;
        logic       reg_clear;
        logic [4:0] gate;
        logic [2:0] track;
        logic [6:0] sector;
    } dcs_cv_ctl_t;
endpackage

//--- verilog/dcs_scheduler.sv
// dcs_scheduler: word-time scheduling of the shared analog converter
// assumes clock track and origin mark arrive as asynchronous pins,
// the option strap is static, and an APB master on ref_clk
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module dcs_scheduler
    import dcs_pkg::*;
#(
    parameter int FDEPTH = FIFO_DEPTH
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              clock_track_reader,
    input  wire logic              drum_origin,
    input  wire logic [1:0]        gate_option,
    input  wire logic              steer_a_ext,
    input  wire logic              steer_b_ext,
    input  wire logic              steer_c_ext,
    input  wire logic              res_valid,
    output var  logic              res_ready,
    input  wire logic [WORD_W-1:0] res_data,
    output var  logic              wr_valid,
    input  wire logic              wr_ready,
    output var  dcs_wr_t           wr_word,
    output var  dcs_cv_ctl_t       cv_ctl,
    output var  logic              clk_phase_a,
    output var  logic              clk_phase_b,
    output var  logic              sector_parity_bit
);
    // pin synchronisers: a change counts once stages 2 and 3 agree
    logic [6:0]    sync1;
    logic [6:0]    sync2;
    logic [6:0]    sync3;
    logic [6:0]    pin_lvl;
    logic          trk_d;
    logic          orig_d;
    logic [1:0]    start_cnt;
    logic          opt_taken;
    dcs_opt_t      opt;
    logic [10:0]   a_gap;
    logic          clock_fault;
    logic          origin_pend;
    logic [4:0]    digit;
    logic [6:0]    sector;
    logic [3:0]    rev_cnt;
    logic [4:0]    step_idx;
    logic [6:0]    conv_cnt;
    dcs_cv_state_t state;
    dcs_cv_state_t next_state;
    logic          ovl;
    logic          clr_pend;
    logic [2:0]    tag_track;
    logic [6:0]    tag_sector;
    logic [6:0]    ctrl;
    logic [3:0]    revlen;
    logic [31:0]   evmask;
    logic [31:0]   refuse_cnt;
    logic [31:0]   rd_data;
    logic          rd_hit;

    wire [6:0] pin_vec  = {gate_option, steer_c_ext, steer_b_ext,
                           steer_a_ext, drum_origin, clock_track_reader};
    wire [6:0] next_lvl = (sync2 & sync3) | (pin_lvl & (sync2 ^ sync3));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1   <= '0;
            sync2   <= '0;
            sync3   <= '0;
            pin_lvl <= '0;
            trk_d   <= 1'b0;
            orig_d  <= 1'b0;
        end else begin
            sync1   <= pin_vec;
            sync2   <= sync1;
            sync3   <= sync2;
            pin_lvl <= next_lvl;
            trk_d   <= opt_taken ? pin_lvl[0] : next_lvl[0];
            orig_d  <= opt_taken ? pin_lvl[1] : next_lvl[1];
        end
    end

    // clock phases from the two edges of the clock track
    wire phase_a_ev = pin_lvl[0] & ~trk_d;
    wire phase_b_ev = ~pin_lvl[0] & trk_d;
    wire orig_rise  = pin_lvl[1] & ~orig_d;

    // strap caught once after the synchroniser has settled
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            start_cnt <= 2'h0;
            opt_taken <= 1'b0;
            opt       <= DCS_OPT_G4;
        end else if (!opt_taken) begin
            start_cnt <= start_cnt + 2'h1;
            if (start_cnt == 2'h3) begin
                opt_taken <= 1'b1;
                opt       <= dcs_opt_t'(next_lvl[6:5]);
            end
        end
    end

    // phase A spacing watch: fault when the track stalls
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            a_gap       <= '0;
            clock_fault <= 1'b0;
        end else if (phase_a_ev) begin
            a_gap       <= '0;
            clock_fault <= 1'b0;
        end else if (a_gap != 11'(CLK_FAULT_CYCLES)) begin
            a_gap <= a_gap + 11'h1;
        end else begin
            clock_fault <= 1'b1;
        end
    end

    // software and pin steering, OR-ed
    wire ctrl_en  = ctrl[CTRL_EN];
    wire every_en = ctrl[CTRL_EVERY];
    wire steer_a  = ctrl[CTRL_STEER_A] | pin_lvl[2];
    wire steer_b  = ctrl[CTRL_STEER_B] | pin_lvl[3];
    wire steer_c  = ctrl[CTRL_STEER_C] | pin_lvl[4];

    wire       word_end  = phase_a_ev & ~origin_pend & (digit == LAST_DIGIT);
    wire [6:0] ns        = sector + 7'h1;
    wire [6:0] ns2       = sector + 7'h2;
    wire       rev_end   = word_end & (ns == 7'h00);
    wire       final_rev = (rev_cnt == revlen) | steer_c;
    wire       under_lim = conv_cnt < MAX_CONV_PER_REV;
    wire       out_ok    = ctrl_en & ctrl[CTRL_OUT_EN] & ~steer_b & under_lim;

    // slot spacing 32/16/8/4 sectors for 4/8/16/32 gates
    function automatic logic slot_hit(input logic [6:0] sec);
        logic [6:0] m;
        m = (7'h20 >> opt) - 7'h01;
        return (sec & m) == ({2'b00, step_idx} & m);
    endfunction

    function automatic logic [4:0] gate_of(input logic [6:0] sec);
        logic [2:0] sh;
        sh = 3'h5 - {1'b0, opt};
        return 5'(sec >> sh);
    endfunction

    function automatic logic in_ok(input logic [6:0] sec);
        return ctrl_en && !steer_a && under_lim && slot_hit(sec)
            && (final_rev || (every_en && evmask[gate_of(sec)]));
    endfunction

    wire [2:0] sh_n   = 3'h5 - {1'b0, opt};
    wire [2:0] trk_n  = 3'(step_idx >> sh_n) & 3'((4'h1 << opt) - 4'h1);
    wire       in_now = in_ok(ns);

    always_comb begin
        next_state = CV_IDLE;
        if (state == CV_IN_CONV) begin
            next_state = CV_IN_WRITE;
        end else if (in_now) begin
            next_state = CV_IN_CONV;
        end else if (!ns[0] && out_ok) begin
            next_state = CV_OUT_FETCH;
        end else if (ns[0] && (state == CV_OUT_FETCH || ovl)) begin
            next_state = CV_OUT_CONV;
        end
    end

    wire next_ovl  = (next_state == CV_IN_WRITE) & ~ns[0] & out_ok;
    wire start_one = (next_state == CV_IN_CONV) | (next_state == CV_OUT_FETCH) | next_ovl;
    wire clr_now   = phase_a_ev & ~origin_pend & (digit == LAST_DIGIT)
                   & (state == CV_OUT_FETCH) & clr_pend & (next_state == CV_IN_CONV);

    // drum position
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            origin_pend <= 1'b0;
            digit       <= '0;
            sector      <= '0;
        end else begin
            if (orig_rise) begin
                origin_pend <= 1'b1;
            end else if (phase_a_ev) begin
                origin_pend <= 1'b0;
            end
            if (phase_a_ev) begin
                if (origin_pend) begin
                    digit  <= '0;
                    sector <= '0;
                end else if (digit == LAST_DIGIT) begin
                    digit  <= '0;
                    sector <= ns;
                end else begin
                    digit <= digit + 5'h01;
                end
            end
        end
    end

    // revolution, final-revolution step and conversion budget
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rev_cnt  <= '0;
            step_idx <= '0;
            conv_cnt <= '0;
        end else if (word_end) begin
            if (rev_end) begin
                conv_cnt <= 7'(start_one);
                if (final_rev) begin
                    rev_cnt  <= '0;
                    step_idx <= step_idx + 5'h01;
                end else begin
                    rev_cnt <= rev_cnt + 4'h1;
                end
            end else if (start_one) begin
                conv_cnt <= conv_cnt + 7'h01;
            end
        end
    end

    // converter sequencing
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= CV_IDLE;
            ovl        <= 1'b0;
            clr_pend   <= 1'b0;
            tag_track  <= '0;
            tag_sector <= '0;
            cv_ctl     <= '0;
        end else begin
            cv_ctl.reg_clear <= clr_now;
            if (word_end) begin
                state              <= next_state;
                ovl                <= next_ovl;
                clr_pend           <= (next_state == CV_OUT_FETCH) & in_ok(ns2);
                cv_ctl.in_conv     <= next_state == CV_IN_CONV;
                cv_ctl.in_write    <= next_state == CV_IN_WRITE;
                cv_ctl.out_fetch   <= (next_state == CV_OUT_FETCH) | next_ovl;
                cv_ctl.out_conv    <= next_state == CV_OUT_CONV;
                cv_ctl.sector      <= ns;
                if (next_state == CV_IN_CONV) begin
                    tag_track    <= trk_n;
                    tag_sector   <= ns;
                    cv_ctl.gate  <= gate_of(ns);
                    cv_ctl.track <= trk_n;
                end
            end
        end
    end

    // input results buffered on their way to the drum
    wire     fifo_ready;
    dcs_wr_t fifo_in;
    assign fifo_in = '{track: tag_track, sector: tag_sector, data: res_data};
    assign res_ready = fifo_ready;

    dcs_fifo #(
        .W     ($bits(dcs_wr_t)),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_valid  (res_valid),
        .in_ready  (fifo_ready),
        .in_data   (fifo_in),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            clk_phase_a       <= 1'b0;
            clk_phase_b       <= 1'b0;
            sector_parity_bit <= 1'b0;
        end else begin
            clk_phase_a       <= phase_a_ev;
            clk_phase_b       <= phase_b_ev;
            sector_parity_bit <= sector[0];
        end
    end

    // APB slave: one wait state, registered answer
    wire acc     = psel & penable;
    wire wr_fire = acc & pready & pwrite;
    wire refused = res_valid & ~fifo_ready;

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        if (paddr == REG_CTRL) begin
            rd_data = 32'(ctrl);
        end else if (paddr == REG_REVLEN) begin
            rd_data = 32'(revlen);
        end else if (paddr == REG_EVMASK) begin
            rd_data = evmask;
        end else if (paddr == REG_STATUS) begin
            rd_data = (32'(sector) << ST_SECTOR) | (32'(digit) << ST_DIGIT)
                    | (32'(opt) << ST_OPT) | (32'(state) << ST_STATE)
                    | (32'(clock_fault) << ST_FAULT) | (32'(final_rev) << ST_FINAL);
        end else if (paddr == REG_COUNT) begin
            rd_data = (32'(conv_cnt) << CN_CONV) | (32'(rev_cnt) << CN_REV)
                    | (32'(step_idx) << CN_STEP);
        end else if (paddr == REG_REFUSE) begin
            rd_data = refuse_cnt;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~rd_hit;
            if (acc && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl   <= CTRL_RST;
            revlen <= REVLEN_RST;
            evmask <= EVMASK_RST;
        end else if (wr_fire && rd_hit) begin
            if (paddr == REG_CTRL) begin
                ctrl <= pwdata[6:0];
            end else if (paddr == REG_REVLEN) begin
                revlen <= pwdata[3:0];
            end else if (paddr == REG_EVMASK) begin
                evmask <= pwdata;
            end
        end
    end

    // refused-result cycles; a new count beats a clearing write
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            refuse_cnt <= '0;
        end else if (refused) begin
            refuse_cnt <= (wr_fire && paddr == REG_REFUSE) ? 32'h0000_0001
                                                           : refuse_cnt + 32'h0000_0001;
        end else if (wr_fire && paddr == REG_REFUSE) begin
            refuse_cnt <= '0;
        end
    end
endmodule // dcs_scheduler
`default_nettype wire
